// *** upbc_defines.svh ***
// Constants for the transceiver-side ULPI bus control and reset block.
// Assumes inclusion by bare name from the package and the design file.
`ifndef UPBC_DEFINES_SVH
`define UPBC_DEFINES_SVH

// Clock and reset timing
`define UPBC_CLK_PERIOD_NS   25
`define UPBC_RESET_MIN_NS    1000
// Least time rounds up to whole cycles
`define UPBC_RESET_MIN_CYC \
  ((`UPBC_RESET_MIN_NS + `UPBC_CLK_PERIOD_NS - 1) / `UPBC_CLK_PERIOD_NS)
`define UPBC_RST_CNT_W       6

// Data path and buffer geometry
`define UPBC_DATA_W          8
`define UPBC_FIFO_DEPTH      8

// Bus value that means no command from the link
`define UPBC_BUS_IDLE        8'h00

`endif

// *** upbc_pkg.sv ***
// Types for the transceiver-side ULPI bus control and reset block.
// Assumes upbc_defines.svh is reachable on the include path.
`include "upbc_defines.svh"

package upbc_pkg;

  // Bus ownership sequencer
  typedef enum logic [2:0] {
    UPBC_LISTEN,
    UPBC_LINK_TX,
    UPBC_TURN_TO_PHY,
    UPBC_PHY_TX,
    UPBC_TURN_TO_LINK
  } upbc_state_t;

endpackage

// *** upbc_ulpi_ctrl.sv ***
// Transceiver-side ULPI bus ownership, stop handling, chip reset and
// reference clock selection, with an 8-word buffer on the send path.
// Assumes sys_clk_i is the interface clock shared with the link, so stop
// and bus data need no synchroniser; the chip reset pin is asynchronous.
`timescale 1ns/100ps
`default_nettype none
`include "upbc_defines.svh"

// Buffer with registered storage, honest full and empty, and a flush.
module upbc_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input  wire logic             sys_clk_i,
  input  wire logic             arst_n_i,
  input  wire logic             flush_i,
  input  wire logic             in_valid_i,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  in_ready_o,
  output logic                  out_valid_o,
  output logic      [WIDTH-1:0] out_data_o,
  input  wire logic             out_ready_i
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0]    wr_ptr_reg;
  logic [AW-1:0]    rd_ptr_reg;
  logic [CW-1:0]    count_reg;
  logic             push;
  logic             pop;

  // Handshakes straight from the fill level
  assign in_ready_o  = (count_reg != CW'(DEPTH));
  assign out_valid_o = (count_reg != '0);
  assign out_data_o  = mem_reg[rd_ptr_reg];
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;

  // Storage; contents need no reset, only the pointers and fill level do
  always_ff @(posedge sys_clk_i) begin
    if (push) begin
      mem_reg[wr_ptr_reg] <= in_data_i;
    end
  end

  // Pointers and fill level; flush drops everything queued
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end else if (flush_i) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH - 1)) ? '0 : wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH - 1)) ? '0 : rd_ptr_reg + 1'b1;
      end
      if (push && !pop) begin
        count_reg <= count_reg + 1'b1;
      end else if (pop && !push) begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end
endmodule

// Function
// - With data to send, the transceiver drives direction high to own the bus.
// - With nothing to send, direction stays low, the bus is released and watched.
// - A stop during link transmit marks the previous cycle's byte as last.
// - While chip reset is low, every ULPI output is released (high impedance).
// - The chip reset pin is asynchronous and is synchronised before use.
// - Reset held low at least 1 us clears registers and state machines on release.
// - Clock-in mode takes the 60MHz clock directly; clock-out uses a reference; the defines assume a 25 ns (40MHz) clock.
// - Next high says the current link byte is taken; the link moves on next cycle.
// - Clock-out mode drives a 60MHz clock and launches signals on its rising edge; the defines time sys_clk_i at 25 ns (40MHz).
module upbc_ulpi_ctrl (
  input  wire logic       sys_clk_i,
  input  wire logic       arst_n_i,
  input  wire logic       active_low_chip_reset_n_i,
  input  wire logic       clock_in_mode_i,
  input  wire logic       ulpi_stop_i,
  input  wire logic [7:0] ulpi_data_i,
  output logic      [7:0] ulpi_data_o,
  output logic            ulpi_data_oe_o,
  output logic            ulpi_dir_o,
  output logic            ulpi_dir_oe_o,
  output logic            ulpi_next_o,
  output logic            ulpi_next_oe_o,
  output logic            interface_clock_output_en_o,
  output logic            reference_clock_bypass_o,
  output logic            core_reset_o,
  input  wire logic       send_valid_i,
  input  wire logic [7:0] send_data_i,
  output logic            send_ready_o,
  output logic            recv_valid_o,
  output logic      [7:0] recv_data_o,
  output logic            recv_last_o,
  input  wire logic       recv_ready_i
);
  import upbc_pkg::*;

  upbc_state_t                  state_reg;
  logic [2:0]                   rst_sync_reg;
  logic                         chip_run_reg;
  logic [`UPBC_RST_CNT_W-1:0]   low_cnt_reg;
  logic                         core_reset_reg;
  logic                         clock_in_reg;
  logic [7:0]                   held_byte_reg;
  logic                         held_valid_reg;
  logic [7:0]                   tx_byte_reg;
  logic                         tx_drive_reg;
  logic                         recv_valid_reg;
  logic [7:0]                   recv_data_reg;
  logic                         recv_last_reg;
  logic                         fifo_valid;
  logic [7:0]                   fifo_data;
  logic                         fifo_pop;
  logic                         link_take;
  logic                         flush;

  // Three-stage pin synchroniser; only stage 2 and 3 are looked at
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rst_sync_reg <= 3'b000;
    end else begin
      rst_sync_reg <= {rst_sync_reg[1:0], active_low_chip_reset_n_i};
    end
  end

  // Run level changes only once two stages agree, filtering a glitch
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      chip_run_reg <= 1'b0;
    end else if (rst_sync_reg[1] == rst_sync_reg[2]) begin
      chip_run_reg <= rst_sync_reg[2];
    end
  end

  // Time the low phase; a short dip suspends but does not clear
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      low_cnt_reg    <= '0;
      core_reset_reg <= 1'b0;
    end else begin
      core_reset_reg <= 1'b0;
      if (!chip_run_reg) begin
        if (low_cnt_reg != `UPBC_RST_CNT_W'(`UPBC_RESET_MIN_CYC)) begin
          low_cnt_reg <= low_cnt_reg + 1'b1;
        end
      end else begin
        low_cnt_reg <= '0;
        if (low_cnt_reg == `UPBC_RST_CNT_W'(`UPBC_RESET_MIN_CYC)) begin
          core_reset_reg <= 1'b1;
        end
      end
    end
  end

  // Clock mode strap caught while suspended, held while running
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      clock_in_reg <= 1'b0;
    end else if (!chip_run_reg) begin
      clock_in_reg <= clock_in_mode_i;
    end
  end

  // Clock-out pad launches on the rising edge of this same clock
  assign interface_clock_output_en_o = chip_run_reg && !clock_in_reg;
  assign reference_clock_bypass_o    = clock_in_reg;
  assign core_reset_o                = core_reset_reg;

  // Everything queued or half-received dies with a suspend
  assign flush = !chip_run_reg || core_reset_reg;

  upbc_fifo #(
    .WIDTH (`UPBC_DATA_W),
    .DEPTH (`UPBC_FIFO_DEPTH)
  ) u_fifo (
    .sys_clk_i   (sys_clk_i),
    .arst_n_i    (arst_n_i),
    .flush_i     (flush),
    .in_valid_i  (send_valid_i),
    .in_data_i   (send_data_i),
    .in_ready_o  (send_ready_o),
    .out_valid_o (fifo_valid),
    .out_data_o  (fifo_data),
    .out_ready_i (fifo_pop)
  );

  // Pop a byte each cycle it can be launched onto the owned bus
  assign fifo_pop  = (state_reg == UPBC_PHY_TX) && fifo_valid && !ulpi_stop_i;
  // Accept link bytes only when the receiver can take one
  assign link_take = (state_reg == UPBC_LINK_TX) && recv_ready_i
                     && !ulpi_stop_i;

  // Ownership sequencer; a turnaround cycle sits at every direction flip
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_reg <= UPBC_LISTEN;
    end else if (flush) begin
      state_reg <= UPBC_LISTEN;
    end else begin
      unique case (state_reg)
        UPBC_LISTEN: begin
          if (ulpi_data_i != `UPBC_BUS_IDLE) begin
            state_reg <= UPBC_LINK_TX;
          end else if (fifo_valid) begin
            state_reg <= UPBC_TURN_TO_PHY;
          end
        end
        UPBC_LINK_TX: begin
          if (ulpi_stop_i) begin
            state_reg <= UPBC_LISTEN;
          end
        end
        UPBC_TURN_TO_PHY: begin
          state_reg <= UPBC_PHY_TX;
        end
        UPBC_PHY_TX: begin
          // Link stop or empty buffer hands the bus back
          if (ulpi_stop_i || !fifo_valid) begin
            state_reg <= UPBC_TURN_TO_LINK;
          end
        end
        UPBC_TURN_TO_LINK: begin
          state_reg <= UPBC_LISTEN;
        end
      endcase
    end
  end

  // Launch register so bus data always leaves a flip-flop
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      tx_byte_reg  <= 8'h00;
      tx_drive_reg <= 1'b0;
    end else begin
      tx_byte_reg  <= fifo_pop ? fifo_data : 8'h00;
      tx_drive_reg <= fifo_pop;
    end
  end

  // One byte held back until the next one or a stop settles its end
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      held_byte_reg  <= 8'h00;
      held_valid_reg <= 1'b0;
      recv_valid_reg <= 1'b0;
      recv_data_reg  <= 8'h00;
      recv_last_reg  <= 1'b0;
    end else begin
      recv_valid_reg <= 1'b0;
      recv_last_reg  <= 1'b0;
      if (flush) begin
        held_valid_reg <= 1'b0;
      end else if (state_reg == UPBC_LINK_TX && ulpi_stop_i) begin
        // Byte seen in the previous cycle closes the packet
        recv_valid_reg <= held_valid_reg;
        recv_data_reg  <= held_byte_reg;
        recv_last_reg  <= held_valid_reg;
        held_valid_reg <= 1'b0;
      end else if (link_take) begin
        recv_valid_reg <= held_valid_reg;
        recv_data_reg  <= held_byte_reg;
        held_byte_reg  <= ulpi_data_i;
        held_valid_reg <= 1'b1;
      end
    end
  end

  // Direction high only in the owned and turn-to-phy phases
  assign ulpi_dir_o     = (state_reg == UPBC_TURN_TO_PHY)
                          || (state_reg == UPBC_PHY_TX);
  // Data driven only after the turnaround, never while listening
  assign ulpi_data_oe_o = chip_run_reg && ulpi_dir_o
                          && (state_reg != UPBC_TURN_TO_PHY);
  assign ulpi_data_o    = tx_byte_reg;
  // Next flags an accepted link byte, or a valid byte while sending
  assign ulpi_next_o    = link_take || (tx_drive_reg
                          && state_reg != UPBC_TURN_TO_PHY);
  // All ULPI outputs released while suspended
  assign ulpi_dir_oe_o  = chip_run_reg;
  assign ulpi_next_oe_o = chip_run_reg;

  assign recv_valid_o = recv_valid_reg;
  assign recv_data_o  = recv_data_reg;
  assign recv_last_o  = recv_last_reg;
endmodule
`default_nettype wire

// *** upbc_ulpi_ctrl_sva.sv ***
// Port-level checker for the ULPI bus control and reset block.
// Assumes one clock domain; the bind below reaches every instance.
`timescale 1ns/100ps
`default_nettype none
module upbc_ulpi_ctrl_sva (
  input wire logic sys_clk_i,
  input wire logic arst_n_i,
  input wire logic active_low_chip_reset_n_i,
  input wire logic ulpi_stop_i,
  input wire logic ulpi_data_oe_o,
  input wire logic ulpi_dir_o,
  input wire logic ulpi_dir_oe_o,
  input wire logic ulpi_next_o,
  input wire logic ulpi_next_oe_o,
  input wire logic interface_clock_output_en_o,
  input wire logic reference_clock_bypass_o,
  input wire logic core_reset_o,
  input wire logic recv_last_o,
  input wire logic recv_valid_o,
  input wire logic recv_ready_i
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!arst_n_i);
  // Five low samples: three sync stages, run flag, then the enables
  susp_float_a: assert property (
    (!active_low_chip_reset_n_i) [*5] |-> !ulpi_dir_oe_o && !ulpi_next_oe_o)
    else $error("driver on in suspend");
  sync_delay_a: assert property (
    $rose(active_low_chip_reset_n_i) && !ulpi_dir_oe_o |=>
    !ulpi_dir_oe_o ##[1:3] ulpi_dir_oe_o) else $error("wake timing off");
  core_pulse_a: assert property (
    core_reset_o |-> ulpi_dir_oe_o ##1 !core_reset_o)
    else $error("core reset pulse wrong");
  // Strap may only move while the port is suspended
  bypass_hold_a: assert property (
    $changed(reference_clock_bypass_o) |-> !$past(ulpi_dir_oe_o))
    else $error("strap changed while running");
  clk_out_a: assert property (
    interface_clock_output_en_o |-> ulpi_dir_oe_o && !reference_clock_bypass_o)
    else $error("clock out in wrong mode");
  dir_own_a: assert property (
    ulpi_data_oe_o |-> ulpi_dir_o && ulpi_dir_oe_o)
    else $error("data driven without owning bus");
  turn_send_a: assert property (
    $rose(ulpi_dir_o) |-> (!ulpi_data_oe_o && !ulpi_next_o) ##1
    (ulpi_data_oe_o && !ulpi_next_o) ##1 ulpi_next_o)
    else $error("turnaround");
  next_gate_a: assert property (
    !ulpi_dir_o && !recv_ready_i |-> !ulpi_next_o)
    else $error("byte taken while receiver busy");
  last_stop_a: assert property (
    recv_last_o |-> recv_valid_o && $past(ulpi_stop_i))
    else $error("last byte without stop");
  cover property ($rose(ulpi_dir_o));
  cover property (recv_last_o);
  cover property (core_reset_o);
endmodule
bind upbc_ulpi_ctrl upbc_ulpi_ctrl_sva i_sva (.*);
`default_nettype wire

// *** upbc_link_model.sv ***
// Behavioural ULPI link controller facing the transceiver block.
// Assumes the bench resolves the shared data wire from both enables.
`timescale 1ns/100ps
`default_nettype none
module upbc_link_model (
  input  wire logic       sys_clk_i,
  input  wire logic       dir_i,
  input  wire logic       next_i,
  input  wire logic [7:0] bus_i,
  output logic      [7:0] link_data_o,
  output logic            link_oe_o,
  output logic            stop_o
);
  logic [7:0] rx_q[$];
  // Link drives only while the transceiver listens
  assign link_oe_o = !dir_i;
  initial begin
    link_data_o = 8'h00;
    stop_o      = 1'b0;
  end
  // Mid-cycle sampling keeps clear of the launch edge
  always @(negedge sys_clk_i) begin
    if (dir_i && next_i) rx_q.push_back(bus_i);
  end
  // Command, then bytes held until taken, then a one-cycle stop
  task automatic xfer(input logic [7:0] q[$]);
    for (int i = 0; i < q.size(); i++) begin
      link_data_o <= q[i];
      if (i > 0) begin
        @(negedge sys_clk_i);
        while (next_i !== 1'b1) @(negedge sys_clk_i);
      end
      @(posedge sys_clk_i);
    end
    link_data_o <= 8'h00;
    stop_o      <= 1'b1;
    @(posedge sys_clk_i);
    stop_o <= 1'b0;
  endtask
endmodule
`default_nettype wire

// *** testbench.sv ***
// Self-checking bench: reset, link receive, buffer fill and send burst.
// Assumes the checker binds itself; the link model sits on the bus.
`timescale 1ns/100ps
`default_nettype none
module testbench;
  logic       sys_clk_i   = 1'b0;
  logic       arst_n_i    = 1'b0;
  logic       chip_rst_n  = 1'b0;
  logic       clk_in_mode = 1'b1;
  logic       r_ready     = 1'b0;
  logic       s_valid     = 1'b0;
  logic [7:0] s_data      = 8'h00;
  logic [7:0] d_out, l_data, bus, r_data;
  logic       d_oe, dir, dir_oe, nxt, nxt_oe, l_oe, stop;
  logic       clk_en, bypass, core_rst, s_ready, r_valid, r_last;
  logic [8:0] rq[$];
  int         miscompares = 0;
  int         check_count = 0;
  int         cyc         = 0;

  always #12.5 sys_clk_i = ~sys_clk_i;
  // Released bus shows the inverse of the link's last byte
  assign bus = d_oe ? d_out : (l_oe ? l_data : ~l_data);

  upbc_ulpi_ctrl i_dut (.sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i),
    .active_low_chip_reset_n_i(chip_rst_n), .clock_in_mode_i(clk_in_mode),
    .ulpi_stop_i(stop), .ulpi_data_i(bus), .ulpi_data_o(d_out),
    .ulpi_data_oe_o(d_oe), .ulpi_dir_o(dir), .ulpi_dir_oe_o(dir_oe),
    .ulpi_next_o(nxt), .ulpi_next_oe_o(nxt_oe),
    .interface_clock_output_en_o(clk_en), .reference_clock_bypass_o(bypass),
    .core_reset_o(core_rst), .send_valid_i(s_valid), .send_data_i(s_data),
    .send_ready_o(s_ready), .recv_valid_o(r_valid), .recv_data_o(r_data),
    .recv_last_o(r_last), .recv_ready_i(r_ready));
  upbc_link_model i_link (.sys_clk_i(sys_clk_i), .dir_i(dir & dir_oe),
    .next_i(nxt & nxt_oe), .bus_i(bus), .link_data_o(l_data),
    .link_oe_o(l_oe), .stop_o(stop));

  // Received bytes with their last flag
  always @(negedge sys_clk_i) if (r_valid === 1'b1) rq.push_back({r_last, r_data});
  // Hang guard, well above the roughly 110 cycles needed
  always @(posedge sys_clk_i) begin
    cyc++;
    if (cyc == 4000) begin
      miscompares++;
      $display("unexpected at %0t: timeout", $time);
      end_sim();
    end
  end

  task automatic check_bit(input logic got, input logic exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: flag %b, want %b", $time, got, exp);
    end
  endtask
  task automatic check_word(input logic [8:0] got, input logic [8:0] exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: byte %h, want %h", $time, got, exp);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d, mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // Long reset in clock-in mode, then a short dip in clock-out mode
  task automatic test_reset();
    int seen;
    seen = 0;
    repeat (45) @(posedge sys_clk_i);
    @(negedge sys_clk_i);
    check_bit(dir_oe | d_oe | nxt_oe, 1'b0);
    @(posedge sys_clk_i);
    chip_rst_n <= 1'b1;
    repeat (8) @(negedge sys_clk_i) seen += int'(core_rst === 1'b1);
    check_bit(seen == 1, 1'b1);
    check_bit(bypass, 1'b1);
    @(posedge sys_clk_i);
    clk_in_mode <= 1'b0;
    chip_rst_n  <= 1'b0;
    repeat (10) @(posedge sys_clk_i);
    chip_rst_n <= 1'b1;
    seen = 0;
    repeat (8) @(negedge sys_clk_i) seen += int'(core_rst === 1'b1);
    check_bit(seen == 0, 1'b1);
    check_bit(clk_en, 1'b1);
    check_bit(bypass, 1'b0);
    $display("test reset done");
  endtask

  task automatic test_recv();
    @(posedge sys_clk_i);
    rq.delete();
    r_ready <= 1'b1;
    i_link.xfer('{8'hA5, 8'h11, 8'h22});
    repeat (3) @(posedge sys_clk_i);
    check_word(rq[0], 9'h011);
    check_word(rq[1], 9'h122);
    $display("test recv done");
  endtask

  // Receiver stalls the link while the send buffer fills up
  task automatic test_fill();
    @(posedge sys_clk_i);
    rq.delete();
    r_ready <= 1'b0;
    fork
      i_link.xfer('{8'h41, 8'h77});
      begin
        repeat (2) @(posedge sys_clk_i);
        for (int i = 0; i < 8; i++) begin
          s_valid <= 1'b1;
          s_data  <= 8'(48 + i);
          @(posedge sys_clk_i);
        end
        s_valid <= 1'b0;
        @(negedge sys_clk_i);
        check_bit(s_ready, 1'b0);
        check_bit(dir, 1'b0);
        @(posedge sys_clk_i);
        r_ready <= 1'b1;
      end
    join
    for (int n = 0; n < 40 && i_link.rx_q.size() < 8; n++) @(posedge sys_clk_i);
    for (int i = 0; i < 8; i++) check_word(i_link.rx_q[i], 9'(48 + i));
    repeat (3) @(negedge sys_clk_i);
    check_bit(dir, 1'b0);
    check_word(rq[0], 9'h177);
    $display("test fill done");
  endtask

  initial begin
    repeat (2) @(posedge sys_clk_i);
    arst_n_i <= 1'b1;
    test_reset();
    test_recv();
    test_fill();
    end_sim();
  end
endmodule
`default_nettype wire
